//--- mec_pkg.sv
// Purpose: shared constants and types for the motion event config and routing block
// Assumes: 32-bit APB data, one aligned word per register at four times its index
// Notes: event vectors travel as packed structs so both pins see one layout

package mec_pkg;

   // ****************************************************************
   // bus and register map
   // ****************************************************************
   localparam int MEC_ADDR_W = 12;
   localparam int MEC_IDX_W = 10;
   localparam logic [MEC_IDX_W-1:0] MEC_IDX_WAKE_THS = 10'h05b;
   localparam logic [MEC_IDX_W-1:0] MEC_IDX_DURATION = 10'h05c;
   localparam logic [MEC_IDX_W-1:0] MEC_IDX_FREE_FALL = 10'h05d;
   localparam logic [MEC_IDX_W-1:0] MEC_IDX_ROUTE_A = 10'h05e;
   localparam logic [MEC_IDX_W-1:0] MEC_IDX_ROUTE_B = 10'h05f;
   localparam logic [MEC_IDX_W-1:0] MEC_IDX_CONTROL = 10'h040;
   localparam logic [MEC_IDX_W-1:0] MEC_IDX_STATUS = 10'h041;
   localparam logic [MEC_IDX_W-1:0] MEC_IDX_MASK = 10'h042;
   localparam logic [MEC_IDX_W-1:0] MEC_IDX_PIN_LEVEL = 10'h043;
   localparam logic [7:0] MEC_CFG_RESET = 8'h00;
   localparam logic [1:0] MEC_WORD_ALIGN = 2'h0;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int MEC_POS_FALL_TOP = 7;
   localparam int MEC_POS_WAKE_PERS_HI = 6;
   localparam int MEC_POS_WAKE_PERS_LO = 5;
   localparam int MEC_POS_WAKE_WEIGHT = 4;
   localparam int MEC_POS_SLEEP_HI = 3;
   localparam int MEC_POS_FALL_LOW_HI = 7;
   localparam int MEC_POS_FALL_LOW_LO = 3;
   localparam int MEC_POS_FALL_THS_HI = 2;
   localparam int MEC_POS_WAKE_THS_HI = 5;
   localparam int MEC_POS_CTRL_BASIC_EN = 0;
   localparam int MEC_POS_CTRL_SLEEP_LVL = 1;
   localparam int MEC_POS_TIME_WRAP = 0;

   // ****************************************************************
   // decode constants
   // ****************************************************************
   localparam logic [12:0] MEC_SLEEP_ZERO_PERIODS = 13'h0010;
   localparam int MEC_SLEEP_STEP_SHIFT = 9;
   localparam int MEC_WAKE_COARSE_SHIFT = 2;
   localparam logic [3:0] MEC_SLEEP_ZERO_CODE = 4'h0;
   localparam logic [8:0] MEC_FALL_MG [8] = '{
      9'h09c, 9'h0db, 9'h0fa, 9'h138, 9'h158, 9'h196, 9'h1d5, 9'h1f4
   };

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int MEC_WRAP_WINDOW_US = 6400;
   localparam int MEC_NS_PER_US = 1000;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic activity_change;
      logic sleep_state;
      logic single_tap;
      logic double_tap;
      logic wakeup;
      logic fall;
      logic orientation;
      logic embedded;
      logic hub_done;
   } mec_motion_s;

   typedef struct packed {
      logic activity;
      logic single_tap;
      logic wakeup;
      logic fall;
      logic double_tap;
      logic orientation;
      logic embedded;
      logic hub_done;
      logic time_wrap;
   } mec_events_s;

   typedef struct packed {
      logic [5:0] fall_periods;
      logic [1:0] wake_periods;
      logic [12:0] sleep_periods;
      logic [7:0] wake_ths_fine;
      logic [8:0] fall_ths_mg;
   } mec_decoded_s;

endpackage : mec_pkg

//--- mec_cfg_decode.sv
// Purpose: turns the duration and threshold fields into engine-ready values
// Assumes: fields come straight from the register flops on the same clock
// Notes: outputs are registered, so they follow a write by one clock

`timescale 1ns/10ps

module mec_cfg_decode
   import mec_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // register fields
   input wire logic [7:0] duration_cfg,
   input wire logic [7:0] fall_cfg,
   input wire logic [7:0] wake_ths_cfg,
   // decoded values
   output mec_pkg::mec_decoded_s decoded
);
   import mec_pkg::*;

   logic [3:0] sleep_entry_delay;
   logic [5:0] wakeup_threshold_value;
   logic [2:0] fall_threshold_code;
   mec_decoded_s next_decoded;

   // ****************************************************************
   // field extraction and scaling
   // ****************************************************************
   assign sleep_entry_delay = duration_cfg[MEC_POS_SLEEP_HI:0];
   assign wakeup_threshold_value = wake_ths_cfg[MEC_POS_WAKE_THS_HI:0];
   assign fall_threshold_code = fall_cfg[MEC_POS_FALL_THS_HI:0];
   // top bit lives in one register, low five in the other
   assign next_decoded.fall_periods = {duration_cfg[MEC_POS_FALL_TOP],
                                       fall_cfg[MEC_POS_FALL_LOW_HI:MEC_POS_FALL_LOW_LO]};
   assign next_decoded.wake_periods =
      duration_cfg[MEC_POS_WAKE_PERS_HI:MEC_POS_WAKE_PERS_LO];
   // zero is a short special case, not zero periods
   assign next_decoded.sleep_periods = (sleep_entry_delay == MEC_SLEEP_ZERO_CODE) ?
      MEC_SLEEP_ZERO_PERIODS : (13'(sleep_entry_delay) << MEC_SLEEP_STEP_SHIFT);
   // common unit is full scale over 2^8; the coarse weight is four of those
   assign next_decoded.wake_ths_fine = duration_cfg[MEC_POS_WAKE_WEIGHT] ?
      8'(wakeup_threshold_value) :
      (8'(wakeup_threshold_value) << MEC_WAKE_COARSE_SHIFT);
   assign next_decoded.fall_ths_mg = MEC_FALL_MG[fall_threshold_code];

   // register the decoded set
   always_ff @(posedge clock) begin
      if (srst) begin
         decoded <= '0;
      end else begin
         decoded <= next_decoded;
      end
   end

endmodule : mec_cfg_decode

//--- mec_pin_route.sv
// Purpose: one interrupt pin: routed events merged onto a registered level
// Assumes: basic events are already gated by the global enable
// Notes: instantiated once per pin; unrouted events never reach the pin

`timescale 1ns/10ps

module mec_pin_route
   import mec_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // events and routing
   input mec_pkg::mec_events_s events,
   input mec_pkg::mec_events_s route,
   // pin
   output logic pin
);
   import mec_pkg::*;

   logic next_pin;

   // any routed event drives the pin
   assign next_pin = |(events & route);

   always_ff @(posedge clock) begin
      if (srst) begin
         pin <= 1'b0;
      end else begin
         pin <= next_pin;
      end
   end

endmodule : mec_pin_route

//--- mec_event_route.sv
// Purpose: motion event settings and two-pin interrupt routing, APB slave
// Assumes: event inputs come from the detection engine on the same clock
// Notes: registers sit at byte address four times their index

`timescale 1ns/10ps

module mec_event_route
   import mec_pkg::*;
#(
   parameter int TS_W = 32,
   parameter int TS_LSB_NS = 25000
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [mec_pkg::MEC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // detection engine
   input mec_pkg::mec_motion_s motion,
   input wire logic [TS_W-1:0] timestamp,
   // decoded settings for the engine
   output mec_pkg::mec_decoded_s decoded,
   // pins and interrupt
   output logic first_interrupt_pin,
   output logic second_interrupt_pin,
   output logic irq
);
   import mec_pkg::*;

   // ****************************************************************
   // timing
   // ****************************************************************
   // a longest time, so the tick count rounds down; never below one tick
   localparam int WRAP_TICKS_RAW = (MEC_WRAP_WINDOW_US * MEC_NS_PER_US) / TS_LSB_NS;
   localparam int WRAP_TICKS = (WRAP_TICKS_RAW < 1) ? 1 : WRAP_TICKS_RAW;
   localparam logic [TS_W-1:0] WRAP_WINDOW = TS_W'(WRAP_TICKS);

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0] wakeup_threshold_config;
   logic [7:0] motion_duration_config;
   logic [7:0] free_fall_config;
   logic [7:0] first_pin_event_routing;
   logic [7:0] second_pin_event_routing;
   logic [1:0] basic_control;
   mec_events_s event_status;
   mec_events_s event_mask;

   // ****************************************************************
   // bus decode
   // ****************************************************************
   wire [MEC_IDX_W-1:0] word_idx = paddr[MEC_ADDR_W-1:2];
   wire aligned = (paddr[1:0] == MEC_WORD_ALIGN);
   wire setup_phase = psel & ~penable;
   wire access_phase = psel & penable;
   wire hit_wake_ths = aligned & (word_idx == MEC_IDX_WAKE_THS);
   wire hit_duration = aligned & (word_idx == MEC_IDX_DURATION);
   wire hit_free_fall = aligned & (word_idx == MEC_IDX_FREE_FALL);
   wire hit_route_a = aligned & (word_idx == MEC_IDX_ROUTE_A);
   wire hit_route_b = aligned & (word_idx == MEC_IDX_ROUTE_B);
   wire hit_control = aligned & (word_idx == MEC_IDX_CONTROL);
   wire hit_status = aligned & (word_idx == MEC_IDX_STATUS);
   wire hit_mask = aligned & (word_idx == MEC_IDX_MASK);
   wire hit_pin_level = aligned & (word_idx == MEC_IDX_PIN_LEVEL);
   wire mapped = hit_wake_ths | hit_duration | hit_free_fall | hit_route_a | hit_route_b |
                 hit_control | hit_status | hit_mask | hit_pin_level;
   // the low byte lane holds all data but bit 8 of status and mask, and only its strobe gates a write
   wire wr_en = access_phase & pwrite & mapped & pstrb[0];
   wire [7:0] wbyte = pwdata[7:0];

   // zero-wait slave; an unmapped or unaligned address answers with an error
   assign pready = access_phase;
   assign pslverr = access_phase & ~mapped;

   // ****************************************************************
   // read mux
   // ****************************************************************
   // read data is taken in the setup cycle so it stands in a flop during access
   wire [31:0] rd_word =
      hit_wake_ths ? 32'(wakeup_threshold_config) :
      hit_duration ? 32'(motion_duration_config) :
      hit_free_fall ? 32'(free_fall_config) :
      hit_route_a ? 32'(first_pin_event_routing) :
      hit_route_b ? 32'(second_pin_event_routing) :
      hit_control ? 32'(basic_control) :
      hit_status ? 32'(event_status) :
      hit_mask ? 32'(event_mask) :
      hit_pin_level ? 32'({second_interrupt_pin, first_interrupt_pin}) :
      32'h0000_0000;

   always_ff @(posedge clock) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (setup_phase & ~pwrite) begin
         prdata <= rd_word;
      end
   end

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   // all fields reset to zero: routing off, shortest durations, lowest codes
   always_ff @(posedge clock) begin
      if (srst) begin
         wakeup_threshold_config <= MEC_CFG_RESET;
         motion_duration_config <= MEC_CFG_RESET;
         free_fall_config <= MEC_CFG_RESET;
      end else if (wr_en) begin
         if (hit_wake_ths) begin
            wakeup_threshold_config <= {2'h0, wbyte[MEC_POS_WAKE_THS_HI:0]};
         end
         if (hit_duration) begin
            motion_duration_config <= wbyte;
         end
         if (hit_free_fall) begin
            free_fall_config <= wbyte;
         end
      end
   end

   // routing and control
   always_ff @(posedge clock) begin
      if (srst) begin
         first_pin_event_routing <= MEC_CFG_RESET;
         second_pin_event_routing <= MEC_CFG_RESET;
         basic_control <= 2'h0;
      end else if (wr_en) begin
         if (hit_route_a) begin
            first_pin_event_routing <= wbyte;
         end
         if (hit_route_b) begin
            second_pin_event_routing <= wbyte;
         end
         if (hit_control) begin
            basic_control <= wbyte[MEC_POS_CTRL_SLEEP_LVL:0];
         end
      end
   end

   // ****************************************************************
   // event shaping
   // ****************************************************************
   wire basic_en = basic_control[MEC_POS_CTRL_BASIC_EN];
   wire sleep_as_level = basic_control[MEC_POS_CTRL_SLEEP_LVL];
   // remaining ticks to wrap is ~timestamp + 1, so within window means ~ts below it
   wire near_wrap = ((~timestamp) < WRAP_WINDOW);
   mec_events_s events;
   assign events.activity = basic_en &
      (sleep_as_level ? motion.sleep_state : motion.activity_change);
   assign events.single_tap = basic_en & motion.single_tap;
   assign events.wakeup = basic_en & motion.wakeup;
   assign events.fall = basic_en & motion.fall;
   assign events.double_tap = basic_en & motion.double_tap;
   assign events.orientation = basic_en & motion.orientation;
   // embedded, hub and timestamp events are not basic, so the enable does not gate them
   assign events.embedded = motion.embedded;
   assign events.hub_done = motion.hub_done;
   assign events.time_wrap = near_wrap;

   // ****************************************************************
   // routing masks
   // ****************************************************************
   // first pin: hub done in bit 0, no timestamp alert on this pin
   mec_events_s route_a;
   assign route_a = {first_pin_event_routing, 1'b0};
   // second pin: same upper layout, bit 0 is the wrap alert, no hub route
   mec_events_s route_b;
   assign route_b = {second_pin_event_routing[7:1], 1'b0,
                     second_pin_event_routing[MEC_POS_TIME_WRAP]};

   mec_pin_route u_pin_a (
      .clock(clock),
      .srst(srst),
      .events(events),
      .route(route_a),
      .pin(first_interrupt_pin)
   );

   mec_pin_route u_pin_b (
      .clock(clock),
      .srst(srst),
      .events(events),
      .route(route_b),
      .pin(second_interrupt_pin)
   );

   // ****************************************************************
   // sticky status, mask and interrupt
   // ****************************************************************
   wire clr_status = wr_en & hit_status;
   // clear mask keeps the status layout: bit 8 from the second lane, the rest from the first
   wire [8:0] clr_bits = clr_status ? {pwdata[8], wbyte} : 9'h000;
   mec_events_s next_status;
   // set beats clear so an event in the clearing cycle survives
   assign next_status = (event_status & ~clr_bits) | events;

   always_ff @(posedge clock) begin
      if (srst) begin
         event_status <= '0;
      end else begin
         event_status <= next_status;
      end
   end

   // status and mask are nine bits: the low byte lane plus bit 8 of the second lane
   wire [8:0] mask_wdata = {pwdata[8], wbyte};

   always_ff @(posedge clock) begin
      if (srst) begin
         event_mask <= '0;
      end else if (wr_en & hit_mask) begin
         event_mask <= mask_wdata;
      end
   end

   // level output, high while any unmasked sticky bit is set
   always_ff @(posedge clock) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_status & event_mask);
      end
   end

   // ****************************************************************
   // decoded settings
   // ****************************************************************
   mec_cfg_decode u_decode (
      .clock(clock),
      .srst(srst),
      .duration_cfg(motion_duration_config),
      .fall_cfg(free_fall_config),
      .wake_ths_cfg(wakeup_threshold_config),
      .decoded(decoded)
   );

endmodule : mec_event_route

//--- mec_host_watch.sv
// Purpose: host side model that watches the two interrupt pins and irq
// Assumes: the device always drives its pins, so no pull level is modelled
// Notes: levels are handed on as seen, the bench judges them

`timescale 1ns/10ps

module mec_host_watch (
   // pins from the device
   input wire logic pin_a,
   input wire logic pin_b,
   input wire logic irq,
   // levels as the host sees them
   output logic [2:0] seen
);
   // plain level read, the host has no latch of its own
   assign seen = {irq, pin_b, pin_a};
endmodule : mec_host_watch

//--- mec_event_route_props.sv
// Purpose: concurrent checks on the routing block ports
// Assumes: shadow copies of the registers are rebuilt from apb writes
// Notes: decoded and pins lag the shadow by one clock

`timescale 1ns/10ps

module mec_event_route_props
   import mec_pkg::*;
#(
   parameter int TS_W = 32,
   parameter int TS_LSB_NS = 25000
) (
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [mec_pkg::MEC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // engine side
   input mec_pkg::mec_motion_s motion,
   input wire logic [TS_W-1:0] timestamp,
   input mec_pkg::mec_decoded_s decoded,
   // pins
   input wire logic first_interrupt_pin,
   input wire logic second_interrupt_pin,
   input wire logic irq
);
   import mec_pkg::*;
   localparam int WRAP_TICKS = 6400000 / TS_LSB_NS;
   localparam logic [8:0] MG [8] = '{9'h09c, 9'h0db, 9'h0fa, 9'h138, 9'h158, 9'h196, 9'h1d5, 9'h1f4};
   logic [7:0] r_th, r_du, r_ff, r_a, r_b, r_c;
   logic [TS_W-1:0] ts_left;
   logic [5:0] basic;
   logic wr, want_a, want_b;
   mec_decoded_s want;
   // only completed, accepted writes move the shadow
   assign wr = psel & penable & pwrite & pready & ~pslverr & pstrb[0];
   assign ts_left = ~timestamp;
   assign basic = {r_c[1] ? motion.sleep_state : motion.activity_change, motion.single_tap,
      motion.wakeup, motion.fall, motion.double_tap, motion.orientation} & {6{r_c[0]}};
   assign want_a = |({basic, motion.embedded, motion.hub_done} & r_a);
   assign want_b = |({basic, motion.embedded, ts_left < WRAP_TICKS} & r_b);
   assign want.fall_periods = {r_du[7], r_ff[7:3]};
   assign want.wake_periods = r_du[6:5];
   assign want.sleep_periods = (r_du[3:0] == 4'h0) ? 13'h0010 : {r_du[3:0], 9'h000};
   assign want.wake_ths_fine = r_du[4] ? {2'h0, r_th[5:0]} : {r_th[5:0], 2'h0};
   assign want.fall_ths_mg = MG[r_ff[2:0]];
   // shadow registers
   always_ff @(posedge clock) begin
      if (srst) begin
         {r_th, r_du, r_ff, r_a, r_b, r_c} <= '0;
      end else if (wr) begin
         if (paddr == {MEC_IDX_WAKE_THS, 2'h0}) r_th <= pwdata[7:0];
         if (paddr == {MEC_IDX_DURATION, 2'h0}) r_du <= pwdata[7:0];
         if (paddr == {MEC_IDX_FREE_FALL, 2'h0}) r_ff <= pwdata[7:0];
         if (paddr == {MEC_IDX_ROUTE_A, 2'h0}) r_a <= pwdata[7:0];
         if (paddr == {MEC_IDX_ROUTE_B, 2'h0}) r_b <= pwdata[7:0];
         if (paddr == {MEC_IDX_CONTROL, 2'h0}) r_c <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   property p_fall_dur; !$past(srst) |-> decoded.fall_periods == $past(want.fall_periods); endproperty
   property p_wake_pers; !$past(srst) |-> decoded.wake_periods == $past(want.wake_periods); endproperty
   property p_wake_ths; !$past(srst) |-> decoded.wake_ths_fine == $past(want.wake_ths_fine); endproperty
   property p_sleep; !$past(srst) |-> decoded.sleep_periods == $past(want.sleep_periods); endproperty
   property p_fall_ths; !$past(srst) |-> decoded.fall_ths_mg == $past(want.fall_ths_mg); endproperty
   property p_pin_a_on; want_a |=> first_interrupt_pin; endproperty
   property p_pin_a_off; !want_a |=> !first_interrupt_pin; endproperty
   property p_pin_b; 1'b1 |=> second_interrupt_pin == $past(want_b); endproperty
   property p_pready; psel && penable |-> pready; endproperty
   property p_unaligned; psel && !penable && paddr[1:0] != 2'h0 ##1 penable |-> pslverr; endproperty
   a_fall_dur: assert property (p_fall_dur) else $error("fall duration wrong");
   a_wake_pers: assert property (p_wake_pers) else $error("wake persistence wrong");
   a_wake_ths: assert property (p_wake_ths) else $error("wake threshold wrong");
   a_sleep: assert property (p_sleep) else $error("sleep delay wrong");
   a_fall_ths: assert property (p_fall_ths) else $error("fall threshold wrong");
   a_pin_a_on: assert property (p_pin_a_on) else $error("pin a missed event");
   a_pin_a_off: assert property (p_pin_a_off) else $error("pin a stray");
   a_pin_b: assert property (p_pin_b) else $error("pin b wrong");
   a_pready: assert property (p_pready) else $error("no ready in access");
   a_unaligned: assert property (p_unaligned) else $error("unaligned not refused");
   c_pin_a: cover property (want_a ##1 first_interrupt_pin);
   c_pin_b: cover property (want_b ##1 second_interrupt_pin);
   c_err: cover property (pslverr);
endmodule : mec_event_route_props

bind mec_event_route mec_event_route_props #(.TS_W(TS_W), .TS_LSB_NS(TS_LSB_NS)) u_props (
   .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .motion(motion), .timestamp(timestamp), .decoded(decoded),
   .first_interrupt_pin(first_interrupt_pin), .second_interrupt_pin(second_interrupt_pin),
   .irq(irq));

//--- tb_mec_event_route.sv
// Purpose: self-checking bench for the motion event config and routing block
// Assumes: zero wait apb, pins one clock behind events
// Notes: narrow timestamp so the wrap window sits at 12'h0f00

`timescale 1ns/10ps

module tb_mec_event_route;
   import mec_pkg::*;
   typedef struct {longint t; logic [2:0] v;} mec_note_s;
   logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0, timestamp = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = '0;
   logic pready, pslverr, pin_a, pin_b, irq, er;
   logic [8:0] motion = '0;
   logic [7:0] du, ff;
   logic [5:0] th;
   logic [2:0] seen;
   mec_decoded_s decoded;
   int miscompares = 0, n_tests = 0, cyc = 0;
   int mpos [8] = '{0, 1, 2, 5, 3, 4, 6, 8};
   logic [8:0] mg [8] = '{9'h09c, 9'h0db, 9'h0fa, 9'h138, 9'h158, 9'h196, 9'h1d5, 9'h1f4};
   logic [9:0] idx [8] = '{MEC_IDX_WAKE_THS, MEC_IDX_DURATION, MEC_IDX_FREE_FALL,
      MEC_IDX_ROUTE_A, MEC_IDX_ROUTE_B, MEC_IDX_CONTROL, MEC_IDX_STATUS, MEC_IDX_MASK};
   mec_note_s notes [$];

   mec_event_route #(.TS_W(12), .TS_LSB_NS(25000)) u_dut (.clock(clock), .srst(srst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .motion(motion),
      .timestamp(timestamp), .decoded(decoded), .first_interrupt_pin(pin_a),
      .second_interrupt_pin(pin_b), .irq(irq));
   mec_host_watch u_host (.pin_a(pin_a), .pin_b(pin_b), .irq(irq), .seen(seen));

   always #2 clock = ~clock;

   task automatic stop_test();
      if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   task automatic check(string nm, logic [63:0] got, logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   // one transfer; request held until pready is sampled high
   task automatic apb(logic wr, logic [9:0] ix, logic [31:0] d, logic [1:0] lo = 2'h0);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {ix, lo};
      pwdata <= d;
      pstrb <= 4'hf;
      @(posedge clock);
      penable <= 1'b1;
      // pready ends this wait; the hang guard catches a slave that never raises it
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      check("pready", pready, 1);
   endtask : apb

   task automatic reg_rd(logic [9:0] ix, logic [31:0] exp);
      apb(0, ix, 32'h0000_0000);
      check("register", rd, exp);
   endtask : reg_rd

   task automatic dec_chk();
      mec_decoded_s e;
      e.fall_periods = {du[7], ff[7:3]};
      e.wake_periods = du[6:5];
      e.sleep_periods = (du[3:0] == 4'h0) ? 13'h0010 : {du[3:0], 9'h000};
      e.wake_ths_fine = du[4] ? {2'h0, th} : {th, 2'h0};
      e.fall_ths_mg = mg[ff[2:0]];
      check("decoded", 64'(decoded), 64'(e));
   endtask : dec_chk

   // one event pulse; notes {irq, pin b, pin a} for the two following edges
   task automatic fire(logic [8:0] m, logic [11:0] ts, logic [2:0] v1, logic [2:0] v2);
      @(posedge clock);
      motion <= m;
      timestamp <= ts;
      notes.push_back('{$time + 4, v1});
      @(posedge clock);
      motion <= 9'h000;
      timestamp <= 12'h000;
      notes.push_back('{$time + 4, v2});
   endtask : fire

   // watcher takes the oldest note when its edge has passed
   always @(posedge clock) begin
      #1;
      if (notes.size() > 0 && notes[0].t == $time - 1) begin
         check("pins", seen, notes[0].v);
         void'(notes.pop_front());
      end
   end

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         stop_test();
      end
   end

   initial begin
      void'($urandom(76));
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      foreach (idx[i]) reg_rd(idx[i], 32'h0000_0000);
      {du, ff, th} = '0;
      dec_chk();
      // refused: unknown index and unaligned write
      apb(0, 10'h3ff, 32'h0000_0000);
      check("slverr", {er, rd}, {1'b1, 32'h0000_0000});
      apb(1, MEC_IDX_ROUTE_A, 32'h0000_00ff, 2'h1);
      reg_rd(MEC_IDX_ROUTE_A, 32'h0000_0000);
      // decode: every fall code, both zero and full boundaries
      for (int i = 0; i < 8; i++) begin
         du = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom());
         ff = {5'($urandom()), 3'(i)};
         th = 6'($urandom());
         apb(1, MEC_IDX_DURATION, {24'h0000_00, du});
         apb(1, MEC_IDX_FREE_FALL, {24'h0000_00, ff});
         apb(1, MEC_IDX_WAKE_THS, {26'h000_0000, th});
         repeat (2) @(posedge clock);
         dec_chk();
         reg_rd(MEC_IDX_DURATION, {24'h0000_00, du});
      end
      // routing: each bit alone, with and without its event
      apb(1, MEC_IDX_CONTROL, 32'h0000_0001);
      for (int p = 0; p < 2; p++) begin
         for (int b = 0; b < 8; b++) begin
            apb(1, p ? MEC_IDX_ROUTE_B : MEC_IDX_ROUTE_A, 32'h0000_0001 << b);
            apb(1, p ? MEC_IDX_ROUTE_A : MEC_IDX_ROUTE_B, 32'h0000_0000);
            fire(9'h1ff, 12'hfff, p ? 3'b010 : 3'b001, 3'b000);
            fire(9'h1ff & ~(9'h001 << mpos[b]), (p && b == 0) ? 12'h000 : 12'hfff, 3'b000, 3'b000);
            if (p && b == 0) begin
               fire(9'h000, 12'hf00, 3'b010, 3'b000);
               fire(9'h000, 12'heff, 3'b000, 3'b000);
            end
         end
      end
      // global enable off, then level mode for activity
      apb(1, MEC_IDX_CONTROL, 32'h0000_0000);
      apb(1, MEC_IDX_ROUTE_A, 32'h0000_00ff);
      apb(1, MEC_IDX_ROUTE_B, 32'h0000_00fe);
      fire(9'h17c, 12'h000, 3'b000, 3'b000);
      fire(9'h002, 12'h000, 3'b011, 3'b000);
      apb(1, MEC_IDX_CONTROL, 32'h0000_0003);
      fire(9'h080, 12'h000, 3'b011, 3'b000);
      fire(9'h100, 12'h000, 3'b000, 3'b000);
      // interrupt: masked wakeup stays quiet, unmasked fall raises irq until cleared
      apb(1, MEC_IDX_CONTROL, 32'h0000_0001);
      apb(1, MEC_IDX_ROUTE_A, 32'h0000_0000);
      apb(1, MEC_IDX_ROUTE_B, 32'h0000_0000);
      apb(1, MEC_IDX_STATUS, 32'h0000_01ff);
      apb(1, MEC_IDX_MASK, 32'h0000_0020);
      fire(9'h010, 12'h000, 3'b000, 3'b000);
      fire(9'h008, 12'h000, 3'b100, 3'b100);
      reg_rd(MEC_IDX_STATUS, 32'h0000_0060);
      reg_rd(MEC_IDX_PIN_LEVEL, 32'h0000_0000);
      apb(1, MEC_IDX_STATUS, 32'h0000_0060);
      @(posedge clock);
      #1;
      check("irq", irq, 0);
      reg_rd(MEC_IDX_STATUS, 32'h0000_0000);
      repeat (4) @(posedge clock);
      stop_test();
   end
endmodule : tb_mec_event_route
